// >>> design/coae_regs.vh
// offsets, fields, opcodes and limits of the core
// Overview of operation
// RL1: one instruction cycle per cpu clock
// RL2: short count for fast ram or none
// RL3: long count for other data areas
// RL4: add read wait per external read
// RL5: add write wait per external write
// RL6: short direct window fe20-ff1f, word even
// RL7: 11-bit call target within 0800-0fff
// RL8: table vectors only even, 0040-007f
// RL9: sfr operands cannot reach ffd0-ffdf
// RL10: eight byte registers x,a,c,b,e,d,l,h
// RL11: four pairs ax,bc,de,hl; ax accumulates
// RL12: odd register is high byte of pair
// RL13: word 16, byte 8, bit 3 bits
// RL14: branch adds signed offset to next pc
// RL15: zero, aux carry, carry follow result
// RL16: return restores the saved status word
// RL17: add with carry writes sum and carry
// RL18: sub with borrow writes result and borrow
// RL19: and, or, xor touch only zero flag
// RL20: word move partner only bc, de, hl
// RL21: word sfr access at even addresses
// RL22: word absolute transfers at even addresses
// RL23: compare updates flags, writes no result
// RL24: exchange is atomic, external costs both waits
`ifndef COAE_REGS_VH
`define COAE_REGS_VH
// port offsets, general registers at 8..f
`define CE_A_CLKSEL 4'h0
`define CE_A_RWAIT  4'h1
`define CE_A_WWAIT  4'h2
`define CE_A_PSW    4'h3
`define CE_A_STAT   4'h4
`define CE_A_PCL    4'h5
`define CE_A_PCH    4'h6
`define CE_A_CYC    4'h7
// status bits
`define CE_PSW_CY   0
`define CE_PSW_AC   4
`define CE_PSW_Z    6
`define CE_PSW_RST  8'h00
`define CE_STAT_BSY 0
`define CE_STAT_FLT 1
// reset values
`define CE_CLKSEL_RST 3'h0
`define CE_WAIT_RST   4'h0
// operations
`define CE_OP_MOV   5'h00
`define CE_OP_XCH   5'h01
`define CE_OP_ADD   5'h02
`define CE_OP_ADD_WITH_CARRY  5'h03
`define CE_OP_SUB   5'h04
`define CE_OP_SUBTRACT_WITH_BORROW  5'h05
`define CE_OP_AND   5'h06
`define CE_OP_OR    5'h07
`define CE_OP_XOR   5'h08
`define CE_OP_CMP   5'h09
`define CE_OP_WORD_MOVE  5'h0a
`define CE_OP_XCHW  5'h0b
`define CE_OP_BR    5'h0c
`define CE_OP_CALLF 5'h0d
`define CE_OP_CALLT 5'h0e
`define CE_OP_RETP  5'h0f
`define CE_OP_ST    5'h10
`define CE_OP_STW   5'h11
// operand modes
`define CE_MD_AR    2'h0
`define CE_MD_RA    2'h1
`define CE_MD_IMM   2'h2
`define CE_MD_MEM   2'h3
// address kinds
`define CE_AK_ABS   2'h0
`define CE_AK_SADR  2'h1
`define CE_AK_SFR   2'h2
// registers
`define CE_R_X      3'h0
`define CE_R_A      3'h1
// address limits
`define CE_SADR_LO  16'hfe20
`define CE_SADR_HI  16'hff1f
`define CE_SFRX_LO  16'hffd0
`define CE_SFRX_HI  16'hffdf
`define CE_C11_LO   16'h0800
`define CE_C11_HI   16'h0fff
`define CE_C11_TOP  5'h01
`define CE_TBL_LO   16'h0040
`define CE_TBL_HI   16'h007f
`endif

// >>> design/coae_alu.v
// byte alu with zero, aux carry and carry results
`timescale 1ns/1ps
`include "coae_regs.vh"
module coae_alu (
  // operation and operands
  input  wire [4:0] op,
  input  wire [7:0] src,
  input  wire [7:0] opd,
  input  wire       cy_in,
  // result and flags
  output reg  [7:0] res,
  output reg        z_o,
  output reg        ac_o,
  output reg        cy_o,
  // write controls
  output reg        wres,
  output reg        f_all,
  output reg        f_z
);
  reg       cin;
  reg [8:0] s9;
  reg [4:0] s5;
  always @* begin
    cin   = 1'b0;
    s9    = 9'h000;
    s5    = 5'h00;
    res   = opd;
    wres  = 1'b0;
    f_all = 1'b0;
    f_z   = 1'b0;
    case (op)
      `CE_OP_ADD, `CE_OP_ADD_WITH_CARRY: begin
        cin   = (op == `CE_OP_ADD_WITH_CARRY) & cy_in; // see RL17
        s9    = {1'b0, src} + {1'b0, opd} + {8'h00, cin};
        s5    = {1'b0, src[3:0]} + {1'b0, opd[3:0]} + {4'h0, cin};
        res   = s9[7:0];
        wres  = 1'b1;
        f_all = 1'b1; // see RL15
      end
      `CE_OP_SUB, `CE_OP_SUBTRACT_WITH_BORROW, `CE_OP_CMP: begin
        cin   = (op == `CE_OP_SUBTRACT_WITH_BORROW) & cy_in; // see RL18
        s9    = {1'b0, src} - {1'b0, opd} - {8'h00, cin};
        s5    = {1'b0, src[3:0]} - {1'b0, opd[3:0]} - {4'h0, cin};
        res   = s9[7:0];
        wres  = (op != `CE_OP_CMP); // see RL23
        f_all = 1'b1;
      end
      `CE_OP_AND: begin
        res  = src & opd;
        wres = 1'b1;
        f_z  = 1'b1; // see RL19
      end
      `CE_OP_OR: begin
        res  = src | opd;
        wres = 1'b1;
        f_z  = 1'b1;
      end
      `CE_OP_XOR: begin
        res  = src ^ opd;
        wres = 1'b1;
        f_z  = 1'b1;
      end
      `CE_OP_MOV: wres = 1'b1;
      default: wres = 1'b0;
    endcase
    z_o  = (res == 8'h00);
    ac_o = s5[4];
    cy_o = s9[8];
  end
endmodule // coae_alu

// >>> design/coae_exec.v
// execution core: operand checks, registers, alu, cycle count
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "coae_regs.vh"
module coae_exec #(
  parameter [15:0] HSRAM_LO = 16'hfb00,
  parameter [15:0] HSRAM_HI = 16'hfeff,
  parameter [15:0] EXT_LO   = 16'h8000,
  parameter [15:0] EXT_HI   = 16'hf7ff
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_ff,
  // decoded instruction
  input  wire        ins_valid,
  input  wire [4:0]  ins_op,
  input  wire [1:0]  ins_mode,
  input  wire [1:0]  ins_akind,
  input  wire [2:0]  ins_reg,
  input  wire [1:0]  register_pair_operand,
  input  wire [15:0] ins_imm,
  input  wire [15:0] ins_addr,
  input  wire [7:0]  branch_displacement,
  input  wire [15:0] ins_pc,
  input  wire [4:0]  ins_cyc_fast,
  input  wire [4:0]  ins_cyc_slow,
  output reg         ins_ready_ff,
  output reg         ins_done_ff,
  output reg         ins_fault_ff,
  // pc load
  output reg  [15:0] pc_out_ff,
  output reg         pc_load_ff,
  // data bus
  output reg  [15:0] mem_addr_ff,
  output reg  [7:0]  mem_wdata_ff,
  output reg         mem_rd_ff,
  output reg         mem_wr_ff,
  input  wire [7:0]  mem_rdata
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RD   = 3'h1;
  localparam [2:0] S_WT   = 3'h2;
  localparam [2:0] S_CAP  = 3'h3;
  localparam [2:0] S_EXE  = 3'h4;
  localparam [2:0] S_WR   = 3'h5;
  localparam [2:0] S_CNT  = 3'h6;

  function in_rng;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // word ops move two bytes
  function f_word;
    input [4:0] op;
    begin
      f_word = (op == `CE_OP_WORD_MOVE) || (op == `CE_OP_XCHW) ||
               (op == `CE_OP_STW) || (op == `CE_OP_CALLT);
    end
  endfunction

  function f_store;
    input [4:0] op;
    begin
      f_store = (op == `CE_OP_ST) || (op == `CE_OP_STW);
    end
  endfunction

  integer i;
  reg [7:0]  gr_ff [0:7];
  reg [2:0]  st_ff;
  reg [4:0]  op_ff;
  reg [1:0]  md_ff;
  reg [1:0]  rp_ff;
  reg [2:0]  r_ff;
  reg [15:0] imm_ff;
  reg [15:0] adr_ff;
  reg [15:0] pcn_ff;
  reg [7:0]  disp_ff;
  reg        idx_ff;
  reg [7:0]  buf0_ff;
  reg [7:0]  buf1_ff;
  reg [7:0]  wlo_ff;
  reg [7:0]  whi_ff;
  reg        nwr_ff;
  reg [7:0]  tot_ff;
  reg [7:0]  cnt_ff;
  reg [7:0]  last_ff;
  reg [7:0]  psw_ff;
  reg [2:0]  processor_clock_select_ff;
  reg [3:0]  rwait_ff;
  reg [3:0]  wwait_ff;
  reg        flt_ff;
  reg [7:0]  div_ff;

  // cpu enable every 2^select clocks
  wire [7:0] div_lim = (8'h01 << processor_clock_select_ff) - 8'h01;
  wire       cpu_en  = (div_ff == div_lim);

  // request kinds
  wire       rq_word  = f_word(ins_op);
  wire       rq_st    = f_store(ins_op);
  wire       rq_flow  = (ins_op == `CE_OP_BR) || (ins_op == `CE_OP_CALLF) ||
                        (ins_op == `CE_OP_CALLT);
  wire       rq_mem   = (ins_mode == `CE_MD_MEM) && !rq_flow;
  wire       rq_rd    = (rq_mem && !rq_st) || (ins_op == `CE_OP_CALLT);
  wire       rq_wr    = rq_mem && (rq_st || ins_op == `CE_OP_XCH);
  wire       rq_odd   = ins_addr[0];
  wire       rq_ext   = rq_mem && in_rng(ins_addr, EXT_LO, EXT_HI);
  wire       rq_slow  = rq_mem && !in_rng(ins_addr, HSRAM_LO, HSRAM_HI);
  wire       rq_w2    = rq_word && !(ins_op == `CE_OP_CALLT);

  wire [7:0] rd_w = !(rq_rd && rq_mem) ? 8'h00 :
                    rq_w2 ? {3'h0, rwait_ff, 1'b0} : {4'h0, rwait_ff};
  wire [7:0] wr_w = !rq_wr ? 8'h00 :
                    rq_w2 ? {3'h0, wwait_ff, 1'b0} : {4'h0, wwait_ff};
  wire [4:0] base = rq_slow ? ins_cyc_slow : ins_cyc_fast; // see RL2 RL3
  wire [7:0] rq_tot = {3'h0, base} + (rq_ext ? rd_w + wr_w : 8'h00); // see RL4 RL5 RL24

  // operand legality
  wire f_sad = (ins_akind == `CE_AK_SADR) &&
               (!in_rng(ins_addr, `CE_SADR_LO, `CE_SADR_HI) || (rq_word && rq_odd)); // see RL6
  wire f_sfr = (ins_akind == `CE_AK_SFR) &&
               (in_rng(ins_addr, `CE_SFRX_LO, `CE_SFRX_HI) || (rq_word && rq_odd)); // see RL9 RL21
  wire f_abs = (ins_akind == `CE_AK_ABS) && rq_word && rq_odd; // see RL22
  wire f_c11 = (ins_op == `CE_OP_CALLF) &&
               !in_rng(ins_addr, `CE_C11_LO, `CE_C11_HI); // see RL7
  wire f_tbl = (ins_op == `CE_OP_CALLT) &&
               (!in_rng(ins_addr, `CE_TBL_LO, `CE_TBL_HI) || rq_odd); // see RL8
  wire f_rp  = ((ins_op == `CE_OP_WORD_MOVE) || (ins_op == `CE_OP_XCHW)) &&
               (ins_mode == `CE_MD_AR || ins_mode == `CE_MD_RA) &&
               (register_pair_operand == 2'h0); // see RL20
  wire rq_bad = (rq_mem && (f_sad || f_sfr || f_abs)) || f_c11 || f_tbl || f_rp;

  // operand fetch
  wire [7:0] a_v = gr_ff[`CE_R_A];
  wire [7:0] x_v = gr_ff[`CE_R_X];
  wire [7:0] r_v = gr_ff[r_ff];
  wire [7:0] rph = gr_ff[{rp_ff, 1'b1}]; // see RL11 RL12
  wire [7:0] rpl = gr_ff[{rp_ff, 1'b0}];
  wire [7:0] alu_src = (md_ff == `CE_MD_RA) ? r_v : a_v;
  wire [7:0] alu_opd = (md_ff == `CE_MD_AR)  ? r_v :
                       (md_ff == `CE_MD_RA)  ? a_v :
                       (md_ff == `CE_MD_IMM) ? imm_ff[7:0] : buf0_ff; // see RL13
  wire [7:0] alu_res;
  wire       alu_z;
  wire       alu_ac;
  wire       alu_cy;
  wire       alu_wres;
  wire       alu_fall;
  wire       alu_fz;

  coae_alu u_alu (
    .op    (op_ff),
    .src   (alu_src),
    .opd   (alu_opd),
    .cy_in (psw_ff[`CE_PSW_CY]),
    .res   (alu_res),
    .z_o   (alu_z),
    .ac_o  (alu_ac),
    .cy_o  (alu_cy),
    .wres  (alu_wres),
    .f_all (alu_fall),
    .f_z   (alu_fz)
  );

  // execute-cycle register writes
  wire       exe = (st_ff == S_EXE);
  reg        we0;
  reg        we1;
  reg        wep;
  reg [2:0]  i0;
  reg [2:0]  i1;
  reg [7:0]  v0;
  reg [7:0]  v1;
  always @* begin
    we0 = 1'b0;
    we1 = 1'b0;
    wep = 1'b0;
    i0  = `CE_R_A;
    i1  = `CE_R_X;
    v0  = alu_res;
    v1  = 8'h00;
    if (exe) begin
      case (op_ff)
        `CE_OP_XCH: begin
          we0 = 1'b1; // see RL24
          v0  = (md_ff == `CE_MD_MEM) ? buf0_ff : r_v;
          we1 = (md_ff != `CE_MD_MEM);
          i1  = r_ff;
          v1  = a_v;
        end
        `CE_OP_WORD_MOVE: begin
          we0 = 1'b1;
          we1 = 1'b1;
          case (md_ff)
            `CE_MD_AR: begin
              v0 = rph;
              v1 = rpl;
            end
            `CE_MD_RA: begin
              i0 = {rp_ff, 1'b1};
              i1 = {rp_ff, 1'b0};
              v0 = a_v;
              v1 = x_v;
            end
            `CE_MD_IMM: begin
              i0 = {rp_ff, 1'b1};
              i1 = {rp_ff, 1'b0};
              v0 = imm_ff[15:8];
              v1 = imm_ff[7:0];
            end
            default: begin
              v0 = buf1_ff;
              v1 = buf0_ff;
            end
          endcase
        end
        `CE_OP_XCHW: begin
          we0 = 1'b1;
          we1 = 1'b1;
          wep = 1'b1;
          v0  = rph;
          v1  = rpl;
        end
        default: begin
          we0 = alu_wres; // see RL10
          i0  = (md_ff == `CE_MD_RA) ? r_ff : `CE_R_A;
        end
      endcase
    end
  end

  // core writes come last so they win
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 8; i = i + 1)
        gr_ff[i] <= 8'h00;
    end else begin
      if (reg_wr && reg_addr[3])
        gr_ff[reg_addr[2:0]] <= reg_wdata;
      if (wep) begin
        gr_ff[{rp_ff, 1'b1}] <= a_v;
        gr_ff[{rp_ff, 1'b0}] <= x_v;
      end
      if (we1)
        gr_ff[i1] <= v1;
      if (we0)
        gr_ff[i0] <= v0;
    end
  end

  // status, configuration, fault
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      psw_ff                    <= `CE_PSW_RST;
      processor_clock_select_ff <= `CE_CLKSEL_RST;
      rwait_ff                  <= `CE_WAIT_RST;
      wwait_ff                  <= `CE_WAIT_RST;
      flt_ff                    <= 1'b0;
      div_ff                    <= 8'h00;
    end else begin
      div_ff <= cpu_en ? 8'h00 : div_ff + 8'h01;
      if (reg_wr) begin
        case (reg_addr)
          `CE_A_CLKSEL: processor_clock_select_ff <= reg_wdata[2:0];
          `CE_A_RWAIT:  rwait_ff <= reg_wdata[3:0];
          `CE_A_WWAIT:  wwait_ff <= reg_wdata[3:0];
          `CE_A_PSW:    psw_ff <= reg_wdata;
          `CE_A_STAT:   if (reg_wdata[`CE_STAT_FLT]) flt_ff <= 1'b0;
          default: ;
        endcase
      end
      // a new fault outranks a clear
      if (st_ff == S_IDLE && ins_valid && rq_bad)
        flt_ff <= 1'b1;
      if (exe) begin
        if (op_ff == `CE_OP_RETP)
          psw_ff <= buf0_ff; // see RL16
        else if (alu_fall) begin
          psw_ff[`CE_PSW_Z]  <= alu_z; // see RL15
          psw_ff[`CE_PSW_AC] <= alu_ac;
          psw_ff[`CE_PSW_CY] <= alu_cy;
        end else if (alu_fz)
          psw_ff[`CE_PSW_Z] <= alu_z;
      end
    end
  end

  // sequencer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff        <= S_IDLE;
      op_ff        <= `CE_OP_MOV;
      md_ff        <= `CE_MD_AR;
      rp_ff        <= 2'h0;
      r_ff         <= 3'h0;
      imm_ff       <= 16'h0000;
      adr_ff       <= 16'h0000;
      pcn_ff       <= 16'h0000;
      disp_ff      <= 8'h00;
      idx_ff       <= 1'b0;
      buf0_ff      <= 8'h00;
      buf1_ff      <= 8'h00;
      wlo_ff       <= 8'h00;
      whi_ff       <= 8'h00;
      nwr_ff       <= 1'b0;
      tot_ff       <= 8'h00;
      cnt_ff       <= 8'h00;
      last_ff      <= 8'h00;
      ins_ready_ff <= 1'b1;
      ins_done_ff  <= 1'b0;
      ins_fault_ff <= 1'b0;
      pc_out_ff    <= 16'h0000;
      pc_load_ff   <= 1'b0;
      mem_addr_ff  <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
    end else begin
      ins_done_ff  <= 1'b0;
      ins_fault_ff <= 1'b0;
      pc_load_ff   <= 1'b0;
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      if (cpu_en && st_ff != S_IDLE)
        cnt_ff <= cnt_ff + 8'h01; // see RL1
      case (st_ff)
        S_IDLE: begin
          if (ins_valid && rq_bad)
            ins_fault_ff <= 1'b1;
          else if (ins_valid) begin
            op_ff        <= ins_op;
            md_ff        <= ins_mode;
            rp_ff        <= register_pair_operand;
            r_ff         <= ins_reg;
            imm_ff       <= ins_imm;
            adr_ff       <= ins_addr;
            pcn_ff       <= ins_pc;
            disp_ff      <= branch_displacement;
            nwr_ff       <= rq_wr;
            tot_ff       <= rq_tot;
            cnt_ff       <= 8'h00;
            idx_ff       <= 1'b0;
            ins_ready_ff <= 1'b0;
            st_ff        <= rq_rd ? S_RD : S_EXE;
          end
        end
        S_RD: begin
          mem_addr_ff <= adr_ff + {15'h0000, idx_ff};
          mem_rd_ff   <= 1'b1;
          st_ff       <= S_WT;
        end
        // read data stand in the cycle after the strobe
        S_WT: st_ff <= S_CAP;
        S_CAP: begin
          if (idx_ff)
            buf1_ff <= mem_rdata;
          else
            buf0_ff <= mem_rdata;
          if (f_word(op_ff) && !idx_ff) begin
            idx_ff <= 1'b1;
            st_ff  <= S_RD;
          end else
            st_ff <= S_EXE;
        end
        S_EXE: begin
          // old accumulator kept so exchange is atomic
          wlo_ff <= (op_ff == `CE_OP_STW) ? x_v : a_v;
          whi_ff <= a_v;
          idx_ff <= 1'b0;
          case (op_ff)
            `CE_OP_BR: begin
              pc_out_ff  <= pcn_ff + {{8{disp_ff[7]}}, disp_ff}; // see RL14
              pc_load_ff <= 1'b1;
            end
            `CE_OP_CALLF: begin
              pc_out_ff  <= {`CE_C11_TOP, adr_ff[10:0]}; // see RL7
              pc_load_ff <= 1'b1;
            end
            `CE_OP_CALLT: begin
              pc_out_ff  <= {buf1_ff, buf0_ff}; // see RL8
              pc_load_ff <= 1'b1;
            end
            default: ;
          endcase
          st_ff <= nwr_ff ? S_WR : S_CNT;
        end
        S_WR: begin
          mem_addr_ff  <= adr_ff + {15'h0000, idx_ff};
          mem_wdata_ff <= idx_ff ? whi_ff : wlo_ff;
          mem_wr_ff    <= 1'b1;
          if (f_word(op_ff) && !idx_ff)
            idx_ff <= 1'b1;
          else
            st_ff <= S_CNT;
        end
        S_CNT: begin
          // a slow bus may outlast the count
          if (cnt_ff >= tot_ff) begin
            ins_done_ff  <= 1'b1;
            ins_ready_ff <= 1'b1;
            last_ff      <= tot_ff;
            st_ff        <= S_IDLE;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // read data one cycle after the strobe
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    case (reg_addr)
      `CE_A_CLKSEL: rd_mux = {5'h00, processor_clock_select_ff};
      `CE_A_RWAIT:  rd_mux = {4'h0, rwait_ff};
      `CE_A_WWAIT:  rd_mux = {4'h0, wwait_ff};
      `CE_A_PSW:    rd_mux = psw_ff;
      `CE_A_STAT:   rd_mux = {6'h00, flt_ff, st_ff != S_IDLE};
      `CE_A_PCL:    rd_mux = pc_out_ff[7:0];
      `CE_A_PCH:    rd_mux = pc_out_ff[15:8];
      `CE_A_CYC:    rd_mux = last_ff;
      default:      rd_mux = gr_ff[reg_addr[2:0]];
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn)
      reg_rdata_ff <= 8'h00;
    else
      reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
  end
endmodule // coae_exec

// >>> tb/coae_chk.sv
// port checker for the core
`timescale 1ns/1ps
`include "coae_regs.vh"
module coae_chk (
  // clock and reset
  input wire        mclk,
  input wire        rstn,
  // instruction side
  input wire        ins_valid,
  input wire [4:0]  ins_op,
  input wire [1:0]  ins_mode,
  input wire [1:0]  ins_akind,
  input wire [1:0]  register_pair_operand,
  input wire [15:0] ins_addr,
  input wire [15:0] ins_pc,
  input wire [7:0]  branch_displacement,
  input wire        ins_ready_ff,
  input wire        ins_done_ff,
  input wire        ins_fault_ff,
  input wire [15:0] pc_out_ff,
  input wire        pc_load_ff,
  // data bus
  input wire        mem_rd_ff,
  input wire        mem_wr_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire        acc = ins_valid && ins_ready_ff;
  wire        brn = ins_op == `CE_OP_BR || ins_op == `CE_OP_CALLF || ins_op == `CE_OP_CALLT;
  wire        mac = acc && !brn && ins_mode == `CE_MD_MEM;
  wire [15:0] ad  = ins_addr;
  logic [15:0] tgt_ff;
  // captured at acceptance, inputs may move later
  always_ff @(posedge mclk) begin
    if (acc) tgt_ff <= ins_pc + {{8{branch_displacement[7]}}, branch_displacement};
  end
  done_pulse_a: assert property (ins_done_ff |=> !ins_done_ff)
    else $error("done too long");
  done_ready_a: assert property ($rose(ins_ready_ff) |-> ins_done_ff)
    else $error("ready rose without done");
  fault_idle_a: assert property (ins_fault_ff |-> ins_ready_ff && !ins_done_ff)
    else $error("fault while busy");
  sadr_win_a: assert property (
    mac && ins_akind == `CE_AK_SADR && (ad < `CE_SADR_LO || ad > `CE_SADR_HI) |=> ins_fault_ff)
    else $error("short direct outside window taken");
  sfr_hole_a: assert property (
    mac && ins_akind == `CE_AK_SFR && ad >= `CE_SFRX_LO && ad <= `CE_SFRX_HI |=> ins_fault_ff)
    else $error("sfr hole taken");
  call_range_a: assert property (
    acc && ins_op == `CE_OP_CALLF && (ad < `CE_C11_LO || ad > `CE_C11_HI) |=> ins_fault_ff)
    else $error("call target out of range taken");
  table_vec_a: assert property (
    acc && ins_op == `CE_OP_CALLT && (ad[0] || ad < `CE_TBL_LO || ad > `CE_TBL_HI)
    |=> ins_fault_ff)
    else $error("bad table vector taken");
  pair_word_a: assert property (
    acc && (ins_op == `CE_OP_WORD_MOVE || ins_op == `CE_OP_XCHW) && ins_mode <= `CE_MD_RA &&
    register_pair_operand == 2'h0 |=> ins_fault_ff)
    else $error("word move with pair zero taken");
  bus_busy_a: assert property (
    mem_rd_ff || mem_wr_ff |-> !ins_ready_ff && !(mem_rd_ff && mem_wr_ff))
    else $error("bus strobe while idle or both");
  branch_tgt_a: assert property (
    acc && ins_op == `CE_OP_BR |=> ##[0:3] pc_load_ff && pc_out_ff == tgt_ff)
    else $error("branch target wrong");
  cover property (acc && ins_op == `CE_OP_XCH);
  cover property (ins_fault_ff);
  cover property (mem_wr_ff);
endmodule // coae_chk

bind coae_exec coae_chk u_chk (.*);

// >>> tb/coae_mem.sv
// far-side data memory and sfr space model
`timescale 1ns/1ps
module coae_mem (
  // clock
  input  wire        mclk,
  // bus from the core
  input  wire [15:0] mem_addr_ff,
  input  wire [7:0]  mem_wdata_ff,
  input  wire        mem_rd_ff,
  input  wire        mem_wr_ff,
  // read answer
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8) ^ 8'h5a);
    mem_rdata = 8'h00;
  end
  // data stand only the cycle after the strobe, moving otherwise
  always @(posedge mclk) begin
    if (mem_rd_ff) mem_rdata <= mem[mem_addr_ff];
    else mem_rdata <= ~mem_rdata;
    if (mem_wr_ff) mem[mem_addr_ff] <= mem_wdata_ff;
  end
endmodule // coae_mem

// >>> tb/cpu_operand_and_alu_execution_bench.sv
// self-checking bench for the core
`timescale 1ns/1ps
`include "coae_regs.vh"
module cpu_operand_and_alu_execution_bench;
  logic        mclk, rstn, reg_wr, reg_rd, ins_valid, ins_ready_ff, ins_done_ff;
  logic        ins_fault_ff, pc_load_ff, mem_rd_ff, mem_wr_ff;
  logic [1:0]  ins_mode, ins_akind, register_pair_operand;
  logic [2:0]  ins_reg;
  logic [3:0]  reg_addr;
  logic [4:0]  ins_op, ins_cyc_fast, ins_cyc_slow;
  logic [7:0]  reg_wdata, reg_rdata_ff, branch_displacement, mem_wdata_ff, mem_rdata;
  logic [15:0] ins_imm, ins_addr, ins_pc, pc_out_ff, mem_addr_ff, e;
  logic [7:0]  a, b, p, mv, mw, r8 [8];
  logic [31:0] seed = 32'd45;
  logic [23:0] ft [12];
  int          cyc, err_total, checks_done;
  coae_exec u_dut (.*);
  coae_mem  u_mem (.*);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #5000000;
    err_total++;
    stop_test;
  end
  function automatic logic [7:0] nr();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // status word above result
  function automatic logic [15:0] alu(input logic [4:0] o, input logic [7:0] x, y, f);
    logic [8:0] s;
    logic       c, h;
    logic [7:0] q;
    q = f;
    c = (o == `CE_OP_ADD_WITH_CARRY || o == `CE_OP_SUBTRACT_WITH_BORROW) && f[`CE_PSW_CY];
    h = f[`CE_PSW_AC];
    case (o)
      `CE_OP_ADD, `CE_OP_ADD_WITH_CARRY: begin
        s = {1'b0, x} + {1'b0, y} + c;
        h = ({1'b0, x[3:0]} + y[3:0] + c) > 5'h0f;
      end
      `CE_OP_AND: s = {f[0], x & y};
      `CE_OP_OR:  s = {f[0], x | y};
      `CE_OP_XOR: s = {f[0], x ^ y};
      default: begin
        s = {1'b0, x} - {1'b0, y} - c;
        h = {1'b0, x[3:0]} < {1'b0, y[3:0]} + c;
      end
    endcase
    q[`CE_PSW_Z]  = s[7:0] == 8'h00;
    q[`CE_PSW_AC] = h;
    q[`CE_PSW_CY] = s[8];
    return {q, (o == `CE_OP_CMP) ? x : s[7:0]};
  endfunction
  task automatic chkv(input logic [15:0] g, input logic [15:0] w);
    checks_done++;
    if (g !== w) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, w);
    end
  endtask
  task automatic wr(input logic [3:0] ra, input logic [7:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {ra, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic chkr(input logic [3:0] ra, input logic [7:0] w);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {ra, 1'b1};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chkv(16'(reg_rdata_ff), 16'(w));
  endtask
  // waits for done, or checks the refusal pulse
  task automatic ex(input logic [4:0] o, input logic [1:0] md, ak, input logic [15:0] ad,
                    input logic f);
    @(posedge mclk);
    {ins_op, ins_mode, ins_akind, ins_addr, ins_valid} <= {o, md, ak, ad, 1'b1};
    @(posedge mclk);
    ins_valid <= 1'b0;
    cyc = 0;
    #1;
    if (f) chkv(16'(ins_fault_ff), 16'h1);
    else while (ins_done_ff !== 1'b1 && cyc < 9000) begin
      @(posedge mclk);
      #1 cyc++;
    end
    if (!f && cyc >= 9000) chkv(16'h0, 16'h1);
  endtask
  task automatic mt(input logic [4:0] o, input logic [15:0] ad, input logic [7:0] t);
    mv = u_mem.mem[ad];
    mw = u_mem.mem[ad + 16'h1];
    ex(o, `CE_MD_MEM, `CE_AK_ABS, ad, 1'b0);
    chkr(4'h7, t);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, ins_valid, ins_op, ins_mode, ins_akind} = '0;
    {ins_reg, register_pair_operand, ins_imm, ins_addr, branch_displacement, ins_pc} = '0;
    {ins_cyc_fast, ins_cyc_slow, rstn} = {5'd12, 5'd20, 1'b0};
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    chkr(4'h3, `CE_PSW_RST);
    for (int i = 0; i < 8; i++) begin
      r8[i] = nr();
      wr(4'(i + 8), r8[i]);
    end
    for (int i = 0; i < 8; i++) chkr(4'(i + 8), r8[i]);
    register_pair_operand <= 2'h2;
    ex(`CE_OP_WORD_MOVE, `CE_MD_AR, 2'h0, 16'h0, 1'b0);
    chkr(4'h9, r8[5]);
    e = {nr(), nr()};
    {ins_imm, register_pair_operand} <= {e, 2'h3};
    ex(`CE_OP_WORD_MOVE, `CE_MD_IMM, 2'h0, 16'h0, 1'b0);
    chkr(4'hf, e[15:8]);
    register_pair_operand <= 2'h0;
    ex(`CE_OP_XCHW, `CE_MD_RA, 2'h0, 16'h0, 1'b1);
    $display("register pairs done");
    ins_reg <= 3'h2;
    // first pass at ff and 01 hits zero and carry edges
    for (int i = 0; i < 24; i++) begin
      a = i < 8 ? 8'hff : nr();
      b = i < 8 ? 8'h01 : nr();
      p = nr();
      wr(4'h9, a);
      wr(4'ha, b);
      wr(4'h3, p);
      ex(`CE_OP_ADD + 5'(i % 8), `CE_MD_AR, 2'h0, 16'h0, 1'b0);
      e = alu(`CE_OP_ADD + 5'(i % 8), a, b, p);
      chkr(4'h9, e[7:0]);
      chkr(4'h3, e[15:8]);
    end
    $display("alu done");
    wr(4'h0, 8'h01);
    ex(`CE_OP_ADD, `CE_MD_AR, 2'h0, 16'h0, 1'b0);
    chkv(16'(cyc >= 22), 16'h1);
    chkr(4'h7, 8'd12);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h03);
    wr(4'h2, 8'h05);
    a = nr();
    wr(4'h9, a);
    mt(`CE_OP_ADD, 16'hfb10, 8'd12);
    chkr(4'h9, a + mv);
    mt(`CE_OP_MOV, 16'h8100, 8'd23);
    a = mv;
    mt(`CE_OP_ST, 16'hf900, 8'd20);
    chkv(16'(u_mem.mem[16'hf900]), 16'(a));
    mt(`CE_OP_XCH, 16'h8300, 8'd28);
    chkv(16'(u_mem.mem[16'h8300]), 16'(a));
    chkr(4'h9, mv);
    mt(`CE_OP_WORD_MOVE, 16'h8400, 8'd26);
    {a, b} = {mw, mv};
    chkr(4'h8, b);
    mt(`CE_OP_STW, 16'h8500, 8'd30);
    chkv({u_mem.mem[16'h8501], u_mem.mem[16'h8500]}, {a, b});
    mt(`CE_OP_RETP, 16'hf902, 8'd20);
    chkr(4'h3, mv);
    mt(`CE_OP_CALLT, 16'h0040, 8'd12);
    chkv(pc_out_ff, {mw, mv});
    $display("memory done");
    for (int i = 0; i < 2; i++) begin
      e = {nr(), nr()};
      b = i ? 8'h80 : 8'h7f;
      {ins_pc, branch_displacement} <= {e, b};
      ex(`CE_OP_BR, `CE_MD_AR, 2'h0, 16'h0, 1'b0);
      chkv(pc_out_ff, e + {{8{b[7]}}, b});
    end
    ex(`CE_OP_CALLF, `CE_MD_AR, 2'h0, 16'h0a55, 1'b0);
    chkv(pc_out_ff, {5'h01, 11'h255});
    ft = '{{1'b0, `CE_OP_MOV, `CE_AK_SADR, 16'hfe20}, {1'b0, `CE_OP_MOV, `CE_AK_SADR, 16'hff1f},
           {1'b1, `CE_OP_MOV, `CE_AK_SADR, 16'hfe1f}, {1'b1, `CE_OP_MOV, `CE_AK_SADR, 16'hff20},
           {1'b1, `CE_OP_WORD_MOVE, `CE_AK_SADR, 16'hfe21}, {1'b1, `CE_OP_MOV, `CE_AK_SFR, 16'hffd0},
           {1'b1, `CE_OP_MOV, `CE_AK_SFR, 16'hffdf}, {1'b1, `CE_OP_WORD_MOVE, `CE_AK_SFR, 16'hff11},
           {1'b1, `CE_OP_WORD_MOVE, `CE_AK_ABS, 16'h8001}, {1'b1, `CE_OP_CALLF, `CE_AK_ABS, 16'h07ff},
           {1'b1, `CE_OP_CALLF, `CE_AK_ABS, 16'h1000}, {1'b1, `CE_OP_CALLT, `CE_AK_ABS, 16'h0041}};
    for (int i = 0; i < 12; i++)
      ex(ft[i][22:18], `CE_MD_MEM, ft[i][17:16], ft[i][15:0], ft[i][23]);
    chkr(4'h4, 8'h02);
    wr(4'h4, 8'h02);
    chkr(4'h4, 8'h00);
    $display("refusals done");
    stop_test;
  end
endmodule // cpu_operand_and_alu_execution_bench
